// ### rtl/flash_host_pkg.sv
// shared constants and types for the parallel flash host controller
package flash_host_pkg;
	// clock and pin timing, figures in ns; synchroniser depth in flops
	localparam int CLK_PERIOD_NS = 4;
	localparam int ACCESS_NS = 70;
	localparam int GLITCH_NS = 5;
	localparam int WE_PULSE_NS = 35;
	localparam int RESET_PULSE_NS = 500;
	localparam int READY_MAX_NS = 20000;
	localparam int SYNC_DEPTH = 2;
	// least times round up, longest times round down
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WE_PULSE_CYC =
		(WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// reset must be held for more than the pulse time, hence one extra
	localparam int RESET_PULSE_CYC =
		(RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int READY_MAX_CYC = READY_MAX_NS / CLK_PERIOD_NS;
	// read sample point: access time plus synchroniser lag
	localparam int READ_CYC = ACCESS_CYC + SYNC_DEPTH;
	// widths
	localparam int ADDR_W = 19;
	localparam int USER_ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int SECTOR_W = 5;
	// user request opcodes
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_HW_RESET = 2'h2;
	localparam logic [1:0] OP_RESET_CMD = 2'h3;
	// reset command data, written to any address
	localparam logic [15:0] RESET_CMD_DATA = 16'h00F0;
	localparam logic [15:0] BYTE_MASK = 16'h00FF;
	// sector map landmarks
	localparam logic [3:0] TOP_NIBBLE = 4'hF;
	localparam logic [3:0] BOTTOM_NIBBLE = 4'h0;
	localparam logic [4:0] SECTOR_32K_TOP = 5'h0F;
	localparam logic [4:0] SECTOR_8K_A_TOP = 5'h10;
	localparam logic [4:0] SECTOR_8K_B_TOP = 5'h11;
	localparam logic [4:0] SECTOR_16K_TOP = 5'h12;
	localparam logic [4:0] SECTOR_16K_BOT = 5'h00;
	localparam logic [4:0] SECTOR_8K_A_BOT = 5'h01;
	localparam logic [4:0] SECTOR_8K_B_BOT = 5'h02;
	localparam logic [4:0] SECTOR_32K_BOT = 5'h03;
	localparam logic [4:0] BOTTOM_64K_BASE = 5'h03;

	typedef logic [15:0] cnt_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD,
		ST_WR_SETUP,
		ST_WR_PULSE,
		ST_WR_HOLD,
		ST_RST_LOW,
		ST_RST_WAIT,
		ST_DONE
	} state_t;
endpackage : flash_host_pkg

// ### rtl/sector_if.sv
// carrier between the controller and its sector decoder
`timescale 1ns/1ps
`default_nettype none
interface sector_if;
	logic [18:0] word_addr;
	logic [4:0] sector_index;
	modport requester (output word_addr, input sector_index);
	modport decoder (input word_addr, output sector_index);
endinterface : sector_if
`default_nettype wire

// ### rtl/sector_decoder.sv
// sector number from word address bits 18..12, top or bottom boot map
`timescale 1ns/1ps
`default_nettype none
module sector_decoder #(
	parameter bit TOP_BOOT = 1'b1
) (
	sector_if.decoder port
);
	logic [6:0] sa;

	assign sa = port.word_addr[18:12];

	// small boot sectors sit at whichever end the variant puts them
	always_comb begin
		port.sector_index = {1'b0, sa[6:3]};
		if (TOP_BOOT) begin
			if (sa[6:3] == flash_host_pkg::TOP_NIBBLE) begin
				if (!sa[2])
					port.sector_index = flash_host_pkg::SECTOR_32K_TOP;
				else if (sa[1])
					port.sector_index = flash_host_pkg::SECTOR_16K_TOP;
				else if (sa[0])
					port.sector_index = flash_host_pkg::SECTOR_8K_B_TOP;
				else
					port.sector_index = flash_host_pkg::SECTOR_8K_A_TOP;
			end
		end else begin
			if (sa[6:3] != flash_host_pkg::BOTTOM_NIBBLE)
				port.sector_index = {1'b0, sa[6:3]} +
					flash_host_pkg::BOTTOM_64K_BASE;
			else if (sa[2])
				port.sector_index = flash_host_pkg::SECTOR_32K_BOT;
			else if (!sa[1])
				port.sector_index = flash_host_pkg::SECTOR_16K_BOT;
			else if (sa[0])
				port.sector_index = flash_host_pkg::SECTOR_8K_B_BOT;
			else
				port.sector_index = flash_host_pkg::SECTOR_8K_A_BOT;
		end
	end
endmodule : sector_decoder
`default_nettype wire

// ### rtl/flash_host.sv
// host-side pin controller for a byte/word parallel boot-sector flash
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - reads hold chip select and output enable low through access time.
// - failure sets bit 5; host writes reset command to recover.
// - after auto-select entry host writes reset command before array reads.
// - command writes drive write enable and chip select low, output high.
// - host writes only defined command sequences.
// - hardware reset held low beyond pulse time returns array read.
// - auto-select uses two unlocks, command, then repeatable reads.
module flash_host #(
	parameter bit TOP_BOOT = 1'b1,
	parameter int READY_MAX_CYC = flash_host_pkg::READY_MAX_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic req,
	input wire logic [1:0] op,
	input wire logic [19:0] addr,
	input wire logic [15:0] wdata,
	input wire logic byte_mode,
	output logic ack,
	output logic busy,
	output logic [15:0] rdata,
	output logic [4:0] sector_index,
	output logic ready_timeout,
	output logic ready,
	output logic [18:0] flash_addr,
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic reset_n,
	output logic byte_n,
	input wire logic [14:0] dq_in,
	output logic [14:0] dq_out,
	output logic dq_oe_n,
	input wire logic top_data_or_low_address_in,
	output logic top_data_or_low_address_out,
	output logic top_data_or_low_address_oe_n,
	input wire logic ready_busy_n
);
	flash_host_pkg::state_t state, next_state;
	flash_host_pkg::cnt_t cnt, next_cnt;
	logic [18:0] next_flash_addr;
	logic low_addr, next_low_addr;
	logic [15:0] dout, next_dout;
	logic [15:0] next_rdata;
	logic [4:0] next_sector_index;
	logic [1:0] op_q, next_op_q;
	logic byte_q, next_byte_q;
	logic boot, next_boot;
	logic next_ready_timeout;
	logic next_ce_n, next_oe_n, next_we_n, next_reset_n;
	logic next_dq_oe_n, next_q15_oe_n;
	logic [15:0] dq_meta, dq_sync;
	logic rdy_meta, rdy_sync;
	sector_if sec ();

	assign sec.word_addr = byte_mode ? addr[19:1] : addr[18:0];
	sector_decoder #(.TOP_BOOT(TOP_BOOT)) sector_decoder_i (.port(sec.decoder));

	// pins from outside pass two flops before anything reads them
	always_ff @(posedge ref_clk) begin
		dq_meta <= {top_data_or_low_address_in, dq_in};
		dq_sync <= dq_meta;
		rdy_meta <= ready_busy_n;
		rdy_sync <= rdy_meta;
	end

	// handshake outputs straight from state
	assign ack = (state == flash_host_pkg::ST_DONE) && !boot;
	assign busy = (state != flash_host_pkg::ST_IDLE);
	assign ready = rdy_sync;
	assign byte_n = !byte_q;
	assign dq_out = dout[14:0];
	// in byte mode the top pin carries the low address bit
	assign top_data_or_low_address_out = byte_q ? low_addr : dout[15];

	// sequencer next values
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_flash_addr = flash_addr;
		next_low_addr = low_addr;
		next_dout = dout;
		next_rdata = rdata;
		next_sector_index = sector_index;
		next_op_q = op_q;
		next_byte_q = byte_q;
		next_boot = boot;
		next_ready_timeout = ready_timeout;
		next_ce_n = ce_n;
		next_oe_n = oe_n;
		next_we_n = we_n;
		next_reset_n = reset_n;
		next_dq_oe_n = dq_oe_n;
		next_q15_oe_n = top_data_or_low_address_oe_n;
		case (state)
			flash_host_pkg::ST_IDLE: begin
				if (req) begin
					next_op_q = op;
					next_byte_q = byte_mode;
					next_flash_addr = sec.word_addr;
					next_low_addr = addr[0];
					next_sector_index = sec.sector_index;
					next_ready_timeout = 1'b0;
					next_q15_oe_n = !byte_mode;
					// byte mode carries only the low eight bits
					next_dout = byte_mode ? (wdata & flash_host_pkg::BYTE_MASK)
						: wdata;
					case (op)
						flash_host_pkg::OP_READ: begin
							// select and output enable low together
							next_ce_n = 1'b0;
							next_oe_n = 1'b0;
							next_cnt = flash_host_pkg::cnt_t'(
								flash_host_pkg::READ_CYC - 1);
							next_state = flash_host_pkg::ST_RD;
						end
						flash_host_pkg::OP_HW_RESET: begin
							// drop the reset pin, bus idle
							next_reset_n = 1'b0;
							next_cnt = flash_host_pkg::cnt_t'(
								flash_host_pkg::RESET_PULSE_CYC - 1);
							next_state = flash_host_pkg::ST_RST_LOW;
						end
						default: begin
							// fixed reset command leaves fail or id
							if (op == flash_host_pkg::OP_RESET_CMD)
								next_dout = flash_host_pkg::RESET_CMD_DATA;
							// select falls first, write enable later
							next_ce_n = 1'b0;
							next_dq_oe_n = 1'b0;
							next_q15_oe_n = 1'b0;
							next_state = flash_host_pkg::ST_WR_SETUP;
						end
					endcase
				end
			end
			flash_host_pkg::ST_RD: begin
				if (cnt == '0) begin
					// word mode uses all sixteen pins
					next_rdata = byte_q ?
						(dq_sync & flash_host_pkg::BYTE_MASK) : dq_sync;
					next_ce_n = 1'b1;
					next_oe_n = 1'b1;
					next_state = flash_host_pkg::ST_DONE;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			flash_host_pkg::ST_WR_SETUP: begin
				// write enable low with output enable held high
				next_we_n = 1'b0;
				next_cnt = flash_host_pkg::cnt_t'(
					flash_host_pkg::WE_PULSE_CYC - 1);
				next_state = flash_host_pkg::ST_WR_PULSE;
			end
			flash_host_pkg::ST_WR_PULSE: begin
				// pulse kept well above the glitch limit
				if (cnt == '0) begin
					next_we_n = 1'b1;
					next_state = flash_host_pkg::ST_WR_HOLD;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			flash_host_pkg::ST_WR_HOLD: begin
				// data still driven one cycle past the rising edge
				next_ce_n = 1'b1;
				next_dq_oe_n = 1'b1;
				next_q15_oe_n = !byte_q;
				next_state = flash_host_pkg::ST_DONE;
			end
			flash_host_pkg::ST_RST_LOW: begin
				if (cnt == '0) begin
					next_reset_n = 1'b1;
					next_cnt = flash_host_pkg::cnt_t'(READY_MAX_CYC - 1);
					next_state = flash_host_pkg::ST_RST_WAIT;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			flash_host_pkg::ST_RST_WAIT: begin
				// wait for ready; bounds the wait
				if (rdy_sync) begin
					next_state = flash_host_pkg::ST_DONE;
				end else if (cnt == '0) begin
					next_ready_timeout = 1'b1;
					next_state = flash_host_pkg::ST_DONE;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			flash_host_pkg::ST_DONE: begin
				next_boot = 1'b0;
				next_state = flash_host_pkg::ST_IDLE;
			end
			default: next_state = flash_host_pkg::ST_IDLE;
		endcase
	end

	// registers; reset starts with a hardware reset pulse of the part
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= flash_host_pkg::ST_RST_LOW;
			cnt <= flash_host_pkg::cnt_t'(flash_host_pkg::RESET_PULSE_CYC - 1);
			flash_addr <= '0;
			low_addr <= 1'b0;
			dout <= '0;
			rdata <= '0;
			sector_index <= '0;
			op_q <= flash_host_pkg::OP_HW_RESET;
			byte_q <= 1'b0;
			boot <= 1'b1;
			ready_timeout <= 1'b0;
			ce_n <= 1'b1;
			oe_n <= 1'b1;
			we_n <= 1'b1;
			reset_n <= 1'b0;
			dq_oe_n <= 1'b1;
			top_data_or_low_address_oe_n <= 1'b1;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			flash_addr <= next_flash_addr;
			low_addr <= next_low_addr;
			dout <= next_dout;
			rdata <= next_rdata;
			sector_index <= next_sector_index;
			op_q <= next_op_q;
			byte_q <= next_byte_q;
			boot <= next_boot;
			ready_timeout <= next_ready_timeout;
			ce_n <= next_ce_n;
			oe_n <= next_oe_n;
			we_n <= next_we_n;
			reset_n <= next_reset_n;
			dq_oe_n <= next_dq_oe_n;
			top_data_or_low_address_oe_n <= next_q15_oe_n;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	read_hold_a: assert property ($fell(oe_n) |-> (!oe_n && !ce_n) [*8])
		else $error("read strobe released too early");
	no_contend_a: assert property (!oe_n |-> dq_oe_n)
		else $error("host drives data while output enabled");
	write_strobe_a: assert property (!we_n |-> (!ce_n && oe_n))
		else $error("write enable low without select or with oe low");
	addr_order_a: assert property ($fell(we_n) |-> !$past(ce_n))
		else $error("write enable fell before chip select");
	data_hold_a: assert property ($rose(we_n) |-> (!dq_oe_n && $stable(dout)))
		else $error("write data not held across rising edge");
	we_width_a: assert property ($fell(we_n) |-> !we_n [*3])
		else $error("write pulse near glitch width");
	rst_pulse_a: assert property ($fell(reset_n) |-> !reset_n [*8])
		else $error("hardware reset pulse too short");
	rst_quiet_a: assert property (!reset_n |-> (ce_n && we_n && oe_n))
		else $error("bus active during hardware reset");
	reset_cmd_a: assert property ((state == flash_host_pkg::ST_WR_PULSE &&
		op_q == flash_host_pkg::OP_RESET_CMD) |->
		dout == flash_host_pkg::RESET_CMD_DATA)
		else $error("reset command data wrong");
	byte_pin_a: assert property (byte_q |-> !top_data_or_low_address_oe_n)
		else $error("low address pin not driven in byte mode");
	ready_seen_a: assert property ((state == flash_host_pkg::ST_RST_WAIT &&
		$past(state) == flash_host_pkg::ST_RST_WAIT &&
		next_state == flash_host_pkg::ST_DONE) |->
		##1 (rdy_sync || ready_timeout))
		else $error("reset finished without ready or timeout");
endmodule : flash_host
`default_nettype wire

// ### bench/flash_model.sv
// behavioural flash device answering the host controller pins
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
	parameter logic [15:0] MAKER_CODE = 16'h0011, // arbitrary value
	parameter logic [15:0] PART_CODE = 16'h0022 // arbitrary value
) (
	input wire logic [18:0] a,
	input wire logic a_low,
	input wire logic [15:0] d,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic reset_n,
	input wire logic byte_n,
	input var int recover_ns,
	input var int prog_ns,
	output logic [15:0] q = 16'h0000,
	output logic ready_busy_n = 1'b0
);
	logic [15:0] mem [int];
	logic [18:0] wa = 19'h00000;
	logic [15:0] pd = 16'h0000;
	logic [2:0] step = 3'h0;
	logic auto = 1'b0, busy = 1'b0, tg = 1'b0, valid = 1'b0;
	logic erasing = 1'b0, susp = 1'b0;
	logic [3:0] esec = 4'h0;
	logic [15:0] erased = 16'h0000;
	realtime wlow = 0.0;
	int erase_ns = 8000;
	logic a_eff;
	int tok = 0, job = 0;
	// pin 15 is an address only in byte mode, else it would loop back
	assign a_eff = ~byte_n & a_low;
	function automatic logic [15:0] word_at(input logic [18:0] w);
		if (mem.exists(w))
			return mem[w];
		// erase works on 64K-aligned regions only, small sectors not split
		return erased[w[18:15]] ? 16'hFFFF : {w[7:0], ~w[7:0]};
	endfunction : word_at
	// what the pins carry on a read
	function automatic logic [15:0] out_word();
		logic [15:0] w;
		w = word_at(a);
		if (!byte_n)
			w = {~q[15:8], a_eff ? w[15:8] : w[7:0]};
		if (auto)
			w = a[0] ? PART_CODE : MAKER_CODE;
		if (susp && a[18:15] == esec)
			w = 16'h0080;
		if (busy)
			w = {8'h00, ~pd[7], tg, 6'h00};
		return w;
	endfunction : out_word
	// data after access time; released pins show the inverse
	always @(a, a_eff, ce_n, oe_n) begin
		if (valid)
			q = ~q;
		valid = 1'b0;
		tok++;
		fork begin
			automatic int t = tok;
			#70;
			if (t == tok && !ce_n && !oe_n) begin
				valid = 1'b1;
				q = out_word();
				tg = ~tg;
			end
		end join_none
	end
	// program, then back to array read on its own
	task automatic program_word(input logic [18:0] pa, input logic [15:0] pv);
		int j;
		step = 3'h0;
		busy = 1'b1;
		ready_busy_n = 1'b0;
		pd = pv;
		job++;
		j = job;
		fork begin
			#(prog_ns);
			if (j == job) begin
				mem[pa] = word_at(pa) & pv;
				busy = 1'b0;
				ready_busy_n = 1'b1;
			end
		end join_none
	endtask : program_word
	// sector erase; no resume, a suspended erase waits for a reset
	task automatic erase_sector(input logic [18:0] ea);
		int j;
		erasing = 1'b1;
		busy = 1'b1;
		ready_busy_n = 1'b0;
		esec = ea[18:15];
		pd = 16'hFFFF;
		job++;
		j = job;
		fork begin
			#(erase_ns);
			if (j == job && !susp) begin
				erased[esec] = 1'b1;
				erasing = 1'b0;
				busy = 1'b0;
				ready_busy_n = 1'b1;
			end
		end join_none
	endtask : erase_sector
	// command decode, reset ignored while busy
	task automatic command(input logic [18:0] ca, input logic [15:0] cd);
		// suspend halts erase, ready again after recovery time
		if (erasing && !susp && cd[7:0] == 8'hB0) begin
			fork begin
				automatic int j = job;
				#(recover_ns);
				if (j == job) begin
					susp = 1'b1;
					busy = 1'b0;
					ready_busy_n = 1'b1;
				end
			end join_none
			return;
		end
		if (busy)
			return;
		if (cd[7:0] == 8'hF0 && step != 3'h3) begin
			step = 3'h0;
			auto = 1'b0;
		end else begin
			case (step)
				3'h0: step = (cd[7:0] == 8'hAA && ca[10:0] == 11'h555) ?
					3'h1 : 3'h0;
				3'h1: step = (cd[7:0] == 8'h55 && ca[10:0] == 11'h2AA) ?
					3'h2 : 3'h0;
				3'h2: begin
					auto = auto | (cd[7:0] == 8'h90);
					step = (cd[7:0] == 8'hA0) ? 3'h3 :
						(cd[7:0] == 8'h80) ? 3'h4 : 3'h0;
				end
				3'h3: program_word(ca, cd);
				3'h4: step = (cd[7:0] == 8'hAA && ca[10:0] == 11'h555) ?
					3'h5 : 3'h0;
				3'h5: step = (cd[7:0] == 8'h55 && ca[10:0] == 11'h2AA) ?
					3'h6 : 3'h0;
				default: begin
					step = 3'h0;
					if (cd[7:0] == 8'h30 && !susp)
						erase_sector(ca);
				end
			endcase
		end
	endtask : command
	// address at the later falling edge
	always @(negedge ce_n, negedge we_n)
		if (!ce_n && !we_n && oe_n) begin
			wa = a;
			wlow = $realtime;
		end
	// data at the earlier rising edge; short pulses ignored
	always @(posedge ce_n, posedge we_n)
		if ((ce_n ^ we_n) === 1'b1 && oe_n && reset_n &&
			$realtime - wlow >= 5.0)
			command(wa, byte_n ? d : {8'h00, d[7:0]});
	// reset aborts work, busy low until read mode
	always @(reset_n) begin
		job++;
		busy = 1'b0;
		step = 3'h0;
		auto = 1'b0;
		erasing = 1'b0;
		susp = 1'b0;
		ready_busy_n = 1'b0;
		if (reset_n === 1'b1) begin
			fork begin
				automatic int j = job;
				#(recover_ns);
				if (j == job)
					ready_busy_n = 1'b1;
			end join_none
		end
	end
endmodule : flash_model
`default_nettype wire

// ### bench/flash_host_bench.sv
// self-checking bench for the parallel flash host controller
`timescale 1ns/1ps
`default_nettype none
module flash_host_bench;
	logic ref_clk = 1'b0, rst = 1'b1, req = 1'b0, byte_mode = 1'b0;
	logic [1:0] op = 2'h0;
	logic [19:0] addr = 20'h00000;
	logic [15:0] wdata = 16'h0000, q, rdata;
	logic ack, busy, ready, ready_timeout, ce_n, oe_n, we_n, reset_n, byte_n;
	logic [4:0] sector_index;
	logic [18:0] flash_addr;
	logic [14:0] dq_out;
	logic dq_oe_n, top_out, top_oe_n, ready_busy_n;
	logic [15:0] bus;
	int recover_ns = 100, prog_ns = 400, fails = 0, samples_checked = 0;
	// wire level from both parties
	assign bus = {top_oe_n ? q[15] : top_out, dq_oe_n ? q[14:0] : dq_out};
	flash_host #(.TOP_BOOT(1'b1), .READY_MAX_CYC(50)) flash_host_i (
		.ref_clk(ref_clk), .rst(rst), .req(req), .op(op), .addr(addr),
		.wdata(wdata), .byte_mode(byte_mode), .ack(ack), .busy(busy),
		.rdata(rdata), .sector_index(sector_index),
		.ready_timeout(ready_timeout), .ready(ready),
		.flash_addr(flash_addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.reset_n(reset_n), .byte_n(byte_n), .dq_in(bus[14:0]),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n),
		.top_data_or_low_address_in(bus[15]),
		.top_data_or_low_address_out(top_out),
		.top_data_or_low_address_oe_n(top_oe_n),
		.ready_busy_n(ready_busy_n));
	flash_model flash_model_i (.a(flash_addr), .a_low(bus[15]), .d(bus),
		.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(reset_n),
		.byte_n(byte_n), .recover_ns(recover_ns), .prog_ns(prog_ns),
		.q(q), .ready_busy_n(ready_busy_n));
	// 250 MHz clock
	initial forever #2 ref_clk = ~ref_clk;
	function automatic logic [15:0] pat(input logic [18:0] w);
		return {w[7:0], ~w[7:0]};
	endfunction : pat
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	// one request, bounded waits for idle and for ack
	task automatic do_op(input logic [1:0] o, input logic [19:0] ad,
		input logic [15:0] wd, input logic bm);
		int n;
		n = 0;
		while (busy !== 1'b0) begin
			@(posedge ref_clk);
			n++;
			if (n > 400) begin
				fails++;
				final_report();
			end
		end
		@(posedge ref_clk);
		req <= 1'b1;
		op <= o;
		addr <= ad;
		wdata <= wd;
		byte_mode <= bm;
		@(posedge ref_clk);
		req <= 1'b0;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
			if (n > 400) begin
				fails++;
				final_report();
			end
		end while (ack !== 1'b1);
	endtask : do_op
	task automatic rd(input logic [19:0] ad);
		do_op(flash_host_pkg::OP_READ, ad, 16'h0000, 1'b0);
	endtask : rd
	task automatic wr(input logic [19:0] ad, input logic [15:0] wd);
		do_op(flash_host_pkg::OP_WRITE, ad, wd, 1'b0);
	endtask : wr
	// unlock pair then a defined command
	task automatic unlock(input logic [15:0] c);
		wr(20'h00555, 16'h00AA);
		wr(20'h002AA, 16'h0055);
		wr(20'h00555, c);
	endtask : unlock
	// read until the word appears, bounded
	task automatic poll(input logic [18:0] w, input logic [15:0] exp);
		int n;
		n = 0;
		do begin
			rd({1'b0, w});
			n++;
		end while (rdata !== exp && n < 60);
		check(rdata, exp); // program completes
	endtask : poll
	task automatic t_map();
		logic [18:0] wa [6] = '{19'h00000, 19'h0FFFF, 19'h7BFFF,
			19'h7C000, 19'h7DFFF, 19'h7E000};
		logic [4:0] si [6] = '{5'h00, 5'h01, 5'h0F, 5'h10, 5'h11, 5'h12};
		for (int i = 0; i < 6; i++) begin
			rd({1'b0, wa[i]});
			check(rdata, pat(wa[i])); // plain array read
			check(sector_index, si[i]); // sector map
		end
		do_op(flash_host_pkg::OP_READ, 20'hFC0A5, 16'h0000, 1'b1);
		check(rdata, 16'h0052); // upper byte
		check(sector_index, 5'h12); // top boot sector
		do_op(flash_host_pkg::OP_READ, 20'hFC0A4, 16'h0000, 1'b1);
		check(rdata, 16'h00AD); // lower byte
		$display("test map done");
	endtask : t_map
	task automatic t_program();
		unlock(16'h00A0);
		wr(20'h00100, 16'h1234);
		poll(19'h00100, pat(19'h00100) & 16'h1234);
		prog_ns = 2000;
		unlock(16'h00A0);
		wr(20'h00200, 16'h0000);
		do_op(flash_host_pkg::OP_RESET_CMD, 20'h00200, 16'h0000, 1'b0);
		rd(20'h00200);
		check(rdata[7], 1'b1); // status, reset ignored
		poll(19'h00200, 16'h0000);
		$display("test program done");
	endtask : t_program
	task automatic t_auto();
		unlock(16'h0090);
		rd(20'h00000);
		check(rdata, flash_model_i.MAKER_CODE); // first code
		rd(20'h00101);
		check(rdata, flash_model_i.PART_CODE); // still codes
		do_op(flash_host_pkg::OP_RESET_CMD, 20'h00000, 16'h0000, 1'b0);
		rd(20'h00101);
		check(rdata, pat(19'h00101)); // array after reset
		$display("test autoselect done");
	endtask : t_auto
	task automatic t_hw_reset();
		prog_ns = 4000;
		unlock(16'h00A0);
		wr(20'h00300, 16'h0000);
		do_op(flash_host_pkg::OP_HW_RESET, 20'h00000, 16'h0000, 1'b0);
		check(ready_timeout, 1'b0); // ready came back
		rd(20'h00300);
		check(rdata, pat(19'h00300)); // program aborted
		recover_ns = 400;
		do_op(flash_host_pkg::OP_HW_RESET, 20'h00000, 16'h0000, 1'b0);
		check(ready_timeout, 1'b1); // busy beyond limit
		recover_ns = 150;
		do_op(flash_host_pkg::OP_HW_RESET, 20'h00000, 16'h0000, 1'b0);
		check(ready_timeout, 1'b0); // slow but in time
		$display("test hardware reset done");
	endtask : t_hw_reset
	// erase suspend: other regions readable, erasing region shows status
	task automatic t_suspend();
		int n;
		unlock(16'h0080);
		wr(20'h00555, 16'h00AA);
		wr(20'h002AA, 16'h0055);
		wr(20'h10000, 16'h0030);
		rd(20'h10040);
		check(rdata[7], 1'b0); // erase polling bit
		wr(20'h10000, 16'h00B0);
		n = 0;
		while (ready !== 1'b1 && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
		check(ready, 1'b1); // suspended within ready time
		rd(20'h20040);
		check(rdata, pat(19'h20040)); // array outside erase
		rd(20'h10040);
		check(rdata, 16'h0080); // status inside erase
		unlock(16'h00A0);
		wr(20'h20080, 16'h0F0F);
		poll(19'h20080, pat(19'h20080) & 16'h0F0F); // program in suspend
		rd(20'h10040);
		check(rdata, 16'h0080); // erasing region still status
		$display("test erase suspend done");
	endtask : t_suspend
	// main sequence
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		t_map();
		t_program();
		t_auto();
		t_suspend();
		t_hw_reset();
		final_report();
	end
endmodule : flash_host_bench
`default_nettype wire
